// >>> dv/ddsw_chk.sv
// Checker on the host-to-device link and the device outputs.
// Assumes host link wires are pclk flops and both ends share pclk.
`timescale 1ns/100ps
`default_nettype none

module ddsw_chk
    import ddsw_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sync_n,
    input wire logic sclk,
    input wire logic [DATA_W-1:0] analog_out_a_code,
    input wire logic [1:0] pwrdn_mode_a,
    input wire logic [1:0] pwrdn_mode_b,
    input wire logic amp_on_a,
    input wire logic amp_on_b,
    input wire logic frame_done,
    input wire logic reserved_err
);
    logic sclk_q;
    logic [4:0] falls;
    logic [7:0] since_last;
    logic fall;

    // Clock falls inside a frame; raw wires are clean host flops
    assign fall = sclk_q && !sclk && !sync_n;

    // Falls per frame, and cycles since the completing fall
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_q <= 1'b0;
            falls <= 5'h00;
            since_last <= 8'hFF;
        end else begin
            sclk_q <= sclk;
            if (sync_n) begin
                falls <= 5'h00;
            end else if (fall && falls != 5'h18) begin
                falls <= falls + 5'h01;
            end
            if (fall && falls == 5'h17) begin
                since_last <= 8'h00;
            end else if (since_last != 8'hFF) begin
                since_last <= since_last + 8'h01;
            end
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_last_fall;
        fall && falls == 5'h17;
    endsequence
    sequence s_done_soon;
        ##[2:6] frame_done;
    endsequence

    property p_done_after_last;
        s_last_fall |-> s_done_soon;
    endproperty
    a_done_after_last: assert property (p_done_after_last) else $error("late execute");
    property p_done_needs_full;
        frame_done |-> falls == 5'h18 && !sync_n;
    endproperty
    a_done_needs_full: assert property (p_done_needs_full) else $error("short execute");
    property p_code_on_done;
        $changed(analog_out_a_code) |-> frame_done;
    endproperty
    a_code_on_done: assert property (p_code_on_done) else $error("stray code");
    property p_mode_on_done;
        $changed(pwrdn_mode_a) || $changed(pwrdn_mode_b) |-> frame_done;
    endproperty
    a_mode_on_done: assert property (p_mode_on_done) else $error("stray mode");
    property p_amp_follows;
        amp_on_a == (pwrdn_mode_a == 2'h0) && amp_on_b == (pwrdn_mode_b == 2'h0);
    endproperty
    a_amp_follows: assert property (p_amp_follows) else $error("amp state");
    property p_hold_full;
        $rose(sync_n) |-> falls == 5'h18;
    endproperty
    a_hold_full: assert property (p_hold_full) else $error("sync rose early");
    property p_gap;
        $fell(sync_n) |-> since_last >= 8'(GAP_CYC - 1); // counter lags the fall by one
    endproperty
    a_gap: assert property (p_gap) else $error("frame gap short");
    property p_start_high;
        $fell(sync_n) |-> sclk;
    endproperty
    a_start_high: assert property (p_start_high) else $error("frame start clock");
    property p_idle_low;
        sync_n |-> !sclk;
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("idle clock moved");
    property p_no_reserved;
        frame_done |-> !reserved_err;
    endproperty
    a_no_reserved: assert property (p_no_reserved) else $error("reserved bit sent");
endmodule

`default_nettype wire

// >>> dv/tb.sv
// Bench: APB into host, host link into device, and a bench-driven
// link into a second device for overrun and abort. Assumes pclk 100 MHz.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module tb
    import ddsw_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [DATA_W-1:0] code_a, code_b, code_a2, code_b2;
    logic [1:0] mode_a, mode_b;
    logic amp_a, amp_b, done, rsv, done2, abort2, rsv2;
    logic [17:0] buf_a, buf_b, cnv_a, cnv_b;
    logic [35:0] exp_q[$];
    logic [35:0] exp_now;
    int n_fail = 0;
    int n_tests = 0;
    int n_done2 = 0;
    int n_abort2 = 0;
    int n_rsv2 = 0;

    ddsw_link_if link1();
    ddsw_link_if link2();
    ddsw_host ddsw_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link1));
    ddsw_device ddsw_device_inst (.pclk(pclk), .presetn(presetn), .link(link1),
        .analog_out_a_code(code_a), .analog_out_b_code(code_b), .pwrdn_mode_a(mode_a),
        .pwrdn_mode_b(mode_b), .amp_on_a(amp_a), .amp_on_b(amp_b), .frame_done(done),
        .frame_abort(), .reserved_err(rsv));
    ddsw_device ddsw_device_inst2 (.pclk(pclk), .presetn(presetn), .link(link2),
        .analog_out_a_code(code_a2), .analog_out_b_code(code_b2), .pwrdn_mode_a(),
        .pwrdn_mode_b(), .amp_on_a(), .amp_on_b(), .frame_done(done2),
        .frame_abort(abort2), .reserved_err(rsv2));
    ddsw_chk ddsw_chk_inst (.pclk(pclk), .presetn(presetn), .sync_n(link1.sync_n),
        .sclk(link1.sclk), .analog_out_a_code(code_a), .pwrdn_mode_a(mode_a),
        .pwrdn_mode_b(mode_b), .amp_on_a(amp_a), .amp_on_b(amp_b), .frame_done(done),
        .reserved_err(rsv));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Oldest noted result against each executed command
    always @(posedge pclk) begin
        if (done === 1'b1) begin
            `CHK("noted", 1'b1, 1'(exp_q.size() != 0))
            exp_now = (exp_q.size() != 0) ? exp_q.pop_front() : 36'h0;
            `CHK("outputs", exp_now, {mode_a, code_a, mode_b, code_b})
        end
    end

    // Pulse counts of the bench-driven device
    always @(posedge pclk) begin
        if (done2 === 1'b1) n_done2++;
        if (abort2 === 1'b1) n_abort2++;
        if (rsv2 === 1'b1) n_rsv2++;
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) n_fail++;
    endtask

    // Command through the host; model buffers, note result, wait idle
    task automatic send(input logic [23:0] c);
        int k;
        apb(1'b1, REG_CMD, {8'h00, c});
        c[23:22] = 2'b00;
        if (c[18]) buf_b = c[17:0]; else buf_a = c[17:0];
        if (c[20]) cnv_a = buf_a;
        if (c[21]) cnv_b = buf_b;
        exp_q.push_back({cnv_a, cnv_b});
        k = 0;
        do begin
            apb(1'b0, REG_STATUS, 32'h0);
            k++;
        end while (rd[ST_BUSY_BIT] !== 1'b0 && k < 200);
        if (k >= 200) n_fail++;
    endtask

    // Bench frame at 125 ns clock period; clock still between frames
    task automatic send2(input logic [23:0] c, input int n, input int extra);
        link2.sync_n = 1'b0;
        for (int i = 0; i < n + extra; i++) begin
            link2.sclk = 1'b1;
            link2.din = c[23];
            c = {c[22:0], 1'($urandom)};
            #62.5 link2.sclk = 1'b0;
            #62.5;
        end
        link2.din = ~link2.din;
        #150 link2.sync_n = 1'b1;
        #100;
    endtask

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #400000;
        n_fail++;
        stop_test;
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        link2.sync_n = 1'b1;
        link2.sclk = 1'b0;
        link2.din = 1'b0;
        {buf_a, buf_b, cnv_a, cnv_b} = '0;
        void'($urandom(89));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        // Power-on state and register map
        `CHK("codes", 32'h0, {code_a, code_b})
        `CHK("amps", 2'h3, {amp_a, amp_b})
        apb(1'b0, REG_DIV, 32'h0);
        `CHK("div", {24'h0, DIV_RST}, rd)
        apb(1'b1, 8'h0C, 32'hFF);
        `CHK("unmapped", 1'b1, err)
        apb(1'b1, REG_DIV, 32'h2);
        $display("test reset done");
        // Buffer A alone, then buffer B loading both channels
        send({4'h0, 1'($urandom), 3'h0, 16'($urandom)});
        send({4'h3, 1'($urandom), 3'h4, 16'($urandom)});
        // Every mode on each channel, ending with wake-up
        for (int i = 1; i <= 4; i++) begin
            send({4'h1, 1'($urandom), 1'b0, 2'(i), 16'($urandom)});
            send({4'h2, 1'($urandom), 1'b1, 2'(i), 16'($urandom)});
        end
        // Power-down into a buffer without load changes no output
        send({4'h0, 1'b0, 3'h7, 16'h0000});
        repeat (8) send({2'b00, 22'($urandom)});
        // A command while busy is dropped and flagged; writing one clears it
        apb(1'b1, REG_CMD, 32'h00115A5A);
        buf_a = 18'h15A5A;
        cnv_a = buf_a;
        exp_q.push_back({cnv_a, cnv_b});
        apb(1'b1, REG_CMD, 32'h00200000);
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK("drop", 2'h3, rd[1:0])
        apb(1'b1, REG_STATUS, 32'h2);
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK("cleared", 1'b0, rd[ST_DROP_BIT])
        while (rd[ST_BUSY_BIT] !== 1'b0) begin
            apb(1'b0, REG_STATUS, 32'h0);
        end
        // Reserved bits never leave the host
        send(24'hC3ABCD);
        apb(1'b0, REG_CMD, 32'h0);
        `CHK("cmd", 32'h0003ABCD, rd)
        repeat (20) @(posedge pclk);
        `CHK("pending", 0, exp_q.size())
        $display("test host link done");
        // Overrun, abort, then a fresh frame with reserved bits set
        @(posedge pclk);
        #3;
        send2({8'h10, 16'hA55A}, 24, 3);
        `CHK("overrun", 16'hA55A, code_a2)
        send2({8'h10, 16'h1234}, 20, 0);
        `CHK("aborts", 1, n_abort2)
        `CHK("kept", 16'hA55A, code_a2)
        send2({8'hE4, 16'h0F0F}, 24, 0);
        `CHK("fresh", 16'h0F0F, code_b2)
        `CHK("executes", 2, n_done2)
        `CHK("reserved flag", 1, n_rsv2)
        $display("test device link done");
        stop_test;
    end
endmodule

`default_nettype wire

// >>> hdl/ddsw_device.sv
// Converter end: serial input register, command decode, buffers and
// converter registers for two channels, plus the output stage mode.
// Assumes link wires are asynchronous to pclk and far slower than it.
`timescale 1ns/100ps
`default_nettype none

module ddsw_device
    import ddsw_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    ddsw_link_if.device link,
    output logic [DATA_W-1:0] analog_out_a_code,
    output logic [DATA_W-1:0] analog_out_b_code,
    output logic [1:0] pwrdn_mode_a,
    output logic [1:0] pwrdn_mode_b,
    output logic amp_on_a,
    output logic amp_on_b,
    output logic frame_done,
    output logic frame_abort,
    output logic reserved_err
);
    typedef struct packed {
        logic sclk_prev;
        logic [FRAME_BITS-1:0] shreg;
        logic [CNT_W-1:0] cnt;
        logic locked;
        logic [DATA_W-1:0] buf_a;
        logic [DATA_W-1:0] buf_b;
        logic [1:0] bpd_a;
        logic [1:0] bpd_b;
        logic [DATA_W-1:0] dac_a;
        logic [DATA_W-1:0] dac_b;
        logic [1:0] pd_a;
        logic [1:0] pd_b;
        logic amp_a;
        logic amp_b;
        logic done;
        logic abort;
        logic rsv_err;
    } ddsw_dev_state_type;

    ddsw_dev_state_type r;
    ddsw_dev_state_type next_r;

    logic [2:0] link_s;
    logic s_sync_n;
    logic s_sclk;
    logic s_din;
    logic fall;
    logic [FRAME_BITS-1:0] word;
    logic load_a;
    logic load_b;
    logic sel_b;
    logic [1:0] pd_bits;

    // All three wires enter through two flops before any logic
    ddsw_sync #(
        .W(3),
        .RST(LINK_RST)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({link.sync_n, link.sclk, link.din}),
        .q(link_s)
    );

    // Synchronised levels, aligned to one another
    assign s_sync_n = link_s[2];
    assign s_sclk = link_s[1];
    assign s_din = link_s[0];

    // Falling serial clock, found from the synchronised level
    assign fall = r.sclk_prev & ~s_sclk;

    // Word as it stands once the current bit is shifted in
    assign word = {r.shreg[FRAME_BITS-2:0], s_din};

    // Control byte above the data half; bit 19 is deliberately never read
    assign load_a = word[LOAD_A_BIT];
    assign load_b = word[LOAD_B_BIT];
    assign sel_b = word[SEL_BIT];
    assign pd_bits = word[PD_HI_BIT:PD_LO_BIT];

    // Frame tracking, decode and update
    always_comb begin
        next_r = r;
        next_r.done = 1'h0;
        next_r.abort = 1'h0;
        next_r.rsv_err = 1'h0;
        next_r.sclk_prev = s_sclk;
        if (s_sync_n) begin
            // High sync ends any frame; partial ones change no buffer but pulse abort
            next_r.abort = (r.cnt != '0) & ~r.locked;
            next_r.shreg = '0;
            next_r.cnt = '0;
            next_r.locked = 1'h0;
        end else if (fall && !r.locked) begin
            // Low sync opens the register for shifting
            next_r.shreg = word;
            next_r.cnt = r.cnt + 1'h1;
            if (r.cnt == CNT_LAST) begin
                // Last bit: lock and execute at once, sync rise not awaited
                next_r.locked = 1'h1;
                next_r.done = 1'h1;
                next_r.rsv_err = |word[RSV_HI_BIT:RSV_LO_BIT];
                // Data word into the chosen buffer with its mode bits
                if (sel_b) begin
                    next_r.buf_b = word[DATA_W-1:0];
                    next_r.bpd_b = pd_bits;
                end else begin
                    next_r.buf_a = word[DATA_W-1:0];
                    next_r.bpd_a = pd_bits;
                end
                // Loads read the freshly written buffers, so both
                // channels may move together in one frame
                if (load_a) begin
                    next_r.dac_a = next_r.buf_a;
                    next_r.pd_a = next_r.bpd_a;
                    next_r.amp_a = (next_r.bpd_a == PD_NORMAL);
                end
                if (load_b) begin
                    next_r.dac_b = next_r.buf_b;
                    next_r.pd_b = next_r.bpd_b;
                    next_r.amp_b = (next_r.bpd_b == PD_NORMAL);
                end
            end
        end
    end

    // Power-on state: zero-scale, normal mode, amplifier running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r.sclk_prev <= 1'h0;
            r.shreg <= '0;
            r.cnt <= '0;
            r.locked <= 1'h0;
            r.buf_a <= CODE_ZERO;
            r.buf_b <= CODE_ZERO;
            r.bpd_a <= PD_NORMAL;
            r.bpd_b <= PD_NORMAL;
            r.dac_a <= CODE_ZERO;
            r.dac_b <= CODE_ZERO;
            r.pd_a <= PD_NORMAL;
            r.pd_b <= PD_NORMAL;
            r.amp_a <= 1'h1;
            r.amp_b <= 1'h1;
            r.done <= 1'h0;
            r.abort <= 1'h0;
            r.rsv_err <= 1'h0;
        end else begin
            r <= next_r;
        end
    end

    // Codes leave as plain unsigned binary; output = ref * code / 65536
    assign analog_out_a_code = r.dac_a;
    assign analog_out_b_code = r.dac_b;
    // Mode drives the output switch: 1k, 100k or open network
    assign pwrdn_mode_a = r.pd_a;
    assign pwrdn_mode_b = r.pd_b;
    assign amp_on_a = r.amp_a;
    assign amp_on_b = r.amp_b;
    assign frame_done = r.done;
    assign frame_abort = r.abort;
    assign reserved_err = r.rsv_err;
endmodule

`default_nettype wire

// >>> hdl/ddsw_host.sv
// Host end: APB slave holding a command word, status and clock divider,
// and a serialiser that plays one 24-bit frame per command.
// Assumes an APB master on pclk; the link clock is made here by division.
`timescale 1ns/100ps
`default_nettype none

module ddsw_host
    import ddsw_pkg::*;
#(
    parameter logic [7:0] DIV_DEFAULT = DIV_RST
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    ddsw_link_if.host link
);
    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_SHIFT = 2'b01,
        H_GAP = 2'b10,
        H_HIGH = 2'b11
    } ddsw_host_st_type;

    typedef struct packed {
        ddsw_host_st_type st;
        logic [FRAME_BITS-1:0] cmd;
        logic [FRAME_BITS-1:0] word;
        logic [7:0] div;
        logic [7:0] tick;
        logic [CNT_W-1:0] bits;
        logic drop;
        logic sync_n;
        logic sclk;
        logic din;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ddsw_host_state_type;

    ddsw_host_state_type r;
    ddsw_host_state_type next_r;

    logic setup;
    logic access;
    logic busy;
    logic [7:0] div_last;

    if (DIV_DEFAULT == 8'h00) begin : g_check
        $error("ddsw_host needs a nonzero divider default");
    end

    assign setup = psel & ~penable;
    assign access = psel & penable & r.pready;
    assign busy = (r.st != H_IDLE);
    // A zero divider would wrap the limit to 255, so it acts as one
    assign div_last = (r.div == 8'h00) ? 8'h00 : r.div - 8'h01;

    always_comb begin
        next_r = r;
        // Zero-wait slave: answer is ready in the first access cycle
        next_r.pready = setup;
        next_r.pslverr = 1'h0;
        if (setup) begin
            unique case (paddr)
                REG_CMD: next_r.prdata = {8'h00, r.cmd};
                REG_STATUS: next_r.prdata = {30'h0, r.drop, busy};
                REG_DIV: next_r.prdata = {24'h0, r.div};
                default: begin
                    next_r.prdata = 32'h0;
                    next_r.pslverr = 1'h1;
                end
            endcase
        end
        // Frame sequencer
        unique case (r.st)
            H_IDLE: begin
            end
            H_SHIFT: begin
                next_r.tick = r.tick + 8'h01;
                if (r.tick >= div_last) begin
                    next_r.tick = 8'h00;
                    if (r.sclk) begin
                        next_r.sclk = 1'h0;
                        next_r.word = {r.word[FRAME_BITS-2:0], 1'h0};
                        next_r.bits = r.bits + 1'h1;
                        if (r.bits == CNT_LAST) begin
                            next_r.st = H_GAP;
                        end
                    end else begin
                        // Data changes on the rise, stable at the fall
                        next_r.sclk = 1'h1;
                        next_r.din = r.word[FRAME_BITS-1];
                    end
                end
            end
            H_GAP: begin
                // Hold sync low, then raise it after the minimum gap
                next_r.tick = r.tick + 8'h01;
                if (r.tick == 8'(GAP_CYC - 1)) begin
                    next_r.tick = 8'h00;
                    next_r.sync_n = 1'h1;
                    next_r.st = H_HIGH;
                end
            end
            H_HIGH: begin
                // Sync high time before the next frame may open
                next_r.tick = r.tick + 8'h01;
                if (r.tick == 8'(SYNC_HIGH_CYC - 1)) begin
                    next_r.tick = 8'h00;
                    next_r.st = H_IDLE;
                end
            end
        endcase
        // Register writes; a command while busy is dropped and noted
        if (access && pwrite) begin
            unique case (paddr)
                REG_CMD: begin
                    if (busy) begin
                        next_r.drop = 1'h1;
                    end else begin
                        next_r.cmd = {2'h0, pwdata[RSV_LO_BIT-1:0]};
                        next_r.word = {2'h0, pwdata[RSV_LO_BIT-1:0]};
                        next_r.din = 1'h0;
                        next_r.sync_n = 1'h0;
                        next_r.sclk = 1'h1;
                        next_r.tick = 8'h00;
                        next_r.bits = '0;
                        next_r.st = H_SHIFT;
                    end
                end
                REG_STATUS: begin
                    // Write one to clear; set comes only from a CMD write,
                    // so set and clear never meet in one cycle
                    if (pwdata[ST_DROP_BIT]) begin
                        next_r.drop = 1'h0;
                    end
                end
                REG_DIV: next_r.div = pwdata[7:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r.st <= H_IDLE;
            r.cmd <= '0;
            r.word <= '0;
            r.div <= DIV_DEFAULT;
            r.tick <= 8'h00;
            r.bits <= '0;
            r.drop <= 1'h0;
            r.sync_n <= 1'h1;
            r.sclk <= 1'h0;
            r.din <= 1'h0;
            r.pready <= 1'h0;
            r.pslverr <= 1'h0;
            r.prdata <= 32'h0;
        end else begin
            r <= next_r;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign link.sync_n = r.sync_n;
    assign link.sclk = r.sclk;
    assign link.din = r.din;
endmodule

`default_nettype wire

// >>> hdl/ddsw_link_if.sv
// Three-wire write link between host controller and converter.
// Assumes the host drives every wire; the device only listens.
`timescale 1ns/100ps
`default_nettype none

interface ddsw_link_if;
    logic sync_n;
    logic sclk;
    logic din;

    modport host (output sync_n, output sclk, output din);
    modport device (input sync_n, input sclk, input din);
endinterface

`default_nettype wire

// >>> hdl/ddsw_pkg.sv
// Constants, field layout and power-down modes of the dual converter write link.
// Assumes both link ends and the bench run on pclk at 100 MHz.

package ddsw_pkg;

    // Frame layout
    localparam int FRAME_BITS = 24;
    localparam int DATA_W = 16;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FRAME_BITS - 1);
    localparam int RSV_HI_BIT = 23;
    localparam int RSV_LO_BIT = 22;
    localparam int LOAD_B_BIT = 21;
    localparam int LOAD_A_BIT = 20;
    localparam int DONT_CARE_BIT = 19;
    localparam int SEL_BIT = 18;
    localparam int PD_HI_BIT = 17;
    localparam int PD_LO_BIT = 16;
    localparam logic [DATA_W-1:0] CODE_ZERO = 16'h0000;

    // Output stage modes
    typedef enum logic [1:0] {
        PD_NORMAL = 2'b00,
        PD_1K = 2'b01,
        PD_100K = 2'b10,
        PD_HIZ = 2'b11
    } ddsw_pd_mode_type;

    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_GAP_NS = 100;
    localparam int T_SYNC_HIGH_NS = 50;
    localparam int GAP_CYC = (T_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_HIGH_CYC = (T_SYNC_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Synchroniser reset image of {sync_n, sclk, din}
    localparam logic [2:0] LINK_RST = 3'h4;

    // Host controller registers
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_CMD = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_DIV = 8'h08;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_DROP_BIT = 1;
    localparam logic [7:0] DIV_RST = 8'h06;

endpackage

// >>> hdl/ddsw_sync.sv
// Two-stage synchroniser for a bundle of asynchronous levels.
// Assumes each bit is an independent slow level relative to pclk.
`timescale 1ns/100ps
`default_nettype none

module ddsw_sync
    import ddsw_pkg::*;
#(
    parameter int W = 3,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] first;
        logic [W-1:0] second;
    } ddsw_sync_state_type;

    ddsw_sync_state_type r;
    ddsw_sync_state_type next_r;

    if (W < 1) begin : g_check
        $error("ddsw_sync needs W of at least one");
    end

    // First stage feeds only the second
    always_comb begin
        next_r = r;
        next_r.first = d;
        next_r.second = r.first;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= {RST, RST};
        end else begin
            r <= next_r;
        end
    end

    assign q = r.second;
endmodule

`default_nettype wire
